// *** design/timed_port_regs.svh ***
// constants for the timed port and its clock blocks
`ifndef TIMED_PORT_REGS_SVH
`define TIMED_PORT_REGS_SVH
`define CNT_WIDTH      16
`define CNT_RESET      16'h0000
`define CNT_STEP       16'h0001
`define NUM_CLKBLK     6
`define CLKBLK_REF     3'h0
`define CLKBLK_W       3
`define DIV_WIDTH      8
`define DIV_RESET      8'h00
`define DIV_STEP       8'h01
`define REF_FREQ_MHZ   100
`define CLK_FREQ_MHZ   40
`define REF_DIV        ((`CLK_FREQ_MHZ + `REF_FREQ_MHZ - 1) / `REF_FREQ_MHZ)
`define WIDTH_CODE_W   3
`endif

// *** design/timed_port_pkg.sv ***
// shared types for the timed port
package timed_port_pkg;
	// port width selection
	typedef enum logic [2:0] {
		w1,
		w4,
		w8,
		w16,
		w32
	} port_width_e;
	// condition for holding off a sample
	typedef enum logic [1:0] {
		cond_none,
		cond_equal,
		cond_differ
	} cond_mode_e;
	// clock source for one clock block
	typedef enum logic [1:0] {
		src_ref,
		src_pin,
		src_divided_ref
	} clk_src_e;
endpackage

// *** design/clock_block.sv ***
// one clock block making a port tick enable
`timescale 1ns/100ps
`include "timed_port_regs.svh"
module clock_block
	import timed_port_pkg::*;
(
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	input  wire logic                     ref_tick,
	input  wire timed_port_pkg::clk_src_e src_sel,
	input  wire logic [`DIV_WIDTH-1:0]    div_ratio,
	input  wire logic                     ext_clk_sync,
	output logic                          tick
);
	import timed_port_pkg::*;

	logic                  ext_prev_reg;
	logic [`DIV_WIDTH-1:0] div_reg;
	logic                  raw_edge;
	logic                  div_done;

	// edge of the already synchronised external clock
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ext_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= ext_clk_sync;
		end
	end

	always_comb begin
		unique case (src_sel)
			src_pin:  raw_edge = ext_clk_sync & ~ext_prev_reg;
			default:  raw_edge = ref_tick;
		endcase
	end

	// optional divide
	// ratio zero bypasses the divider
	assign div_done = (div_reg >= div_ratio);
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			div_reg <= `DIV_RESET;
		end else if (raw_edge && src_sel != src_ref) begin
			div_reg <= div_done ? `DIV_RESET : div_reg + `DIV_STEP;
		end
	end

	assign tick = raw_edge && (src_sel == src_ref || div_done);
endmodule

// *** design/port_counter.sv ***
// free running port counter with timed match
`timescale 1ns/100ps
`include "timed_port_regs.svh"
module port_counter (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire logic                  tick,
	input  wire logic                  time_armed,
	input  wire logic [`CNT_WIDTH-1:0] time_value,
	output logic [`CNT_WIDTH-1:0]      count,
	output logic                       time_hit
);
	logic [`CNT_WIDTH-1:0] count_reg;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			count_reg <= `CNT_RESET;
		end else if (tick) begin
			count_reg <= count_reg + `CNT_STEP;
		end
	end

	assign count = count_reg;
	assign time_hit = !time_armed || (count_reg == time_value);
endmodule

// *** design/timed_io_port.sv ***
// timed io port with clock blocks and pin sharing
`timescale 1ns/100ps
`include "timed_port_regs.svh"
module timed_io_port
	import timed_port_pkg::*;
#(
	parameter int PINS = 32
)(
	input  wire logic                          clock,
	input  wire logic                          rst_n,
	input  wire logic                          port_enable,
	input  wire timed_port_pkg::port_width_e   width_sel,
	input  wire logic                          dir_out,
	input  wire logic                          open_drain,
	input  wire logic                          link_enable,
	input  wire logic [PINS-1:0]               narrow_claim,
	input  wire logic [`CLKBLK_W-1:0]          clkblk_sel,
	input  wire logic                          clkblk_set,
	input  wire logic [`CLKBLK_W-1:0]          cfg_blk,
	input  wire timed_port_pkg::clk_src_e      cfg_src,
	input  wire logic [`DIV_WIDTH-1:0]         cfg_div,
	input  wire logic                          cfg_write,
	input  wire logic                          ext_clk_pin,
	input  wire timed_port_pkg::cond_mode_e    cond_mode,
	input  wire logic [PINS-1:0]               cond_value,
	input  wire logic                          time_armed,
	input  wire logic [`CNT_WIDTH-1:0]         time_value,
	input  wire logic                          out_req,
	input  wire logic [PINS-1:0]               out_word,
	input  wire logic                          in_req,
	input  wire logic                          strobe_in_enable,
	input  wire logic                          input_ready_strobe,
	input  wire logic [PINS-1:0]               pin_in,
	output logic [PINS-1:0]                    pin_out,
	output logic [PINS-1:0]                    pin_oe_n,
	output logic                               output_qualify_strobe,
	output logic                               out_ready,
	output logic                               in_valid,
	output logic [PINS-1:0]                    in_word,
	output logic [`CNT_WIDTH-1:0]              count,
	output logic [`CNT_WIDTH-1:0]              timestamp,
	output logic                               port_event
);
	import timed_port_pkg::*;

	logic [1:0]                 ext_sync_reg;
	logic [1:0]                 strobe_sync_reg;
	logic [PINS-1:0]            pin_sync1_reg;
	logic [PINS-1:0]            pin_sync2_reg;
	logic [`CLKBLK_W-1:0]       sel_reg;
	clk_src_e                   src_reg [`NUM_CLKBLK];
	logic [`DIV_WIDTH-1:0]      div_reg [`NUM_CLKBLK];
	logic [`NUM_CLKBLK-1:0]     blk_tick;
	logic [7:0]                 ref_cnt_reg;
	logic                       ref_tick;
	logic                       tick;
	logic                       time_hit;
	logic [PINS-1:0]            width_mask;
	logic [PINS-1:0]            own_mask;
	logic [PINS-1:0]            xfer_reg;
	logic                       xfer_full_reg;
	logic [PINS-1:0]            shift_reg;
	logic                       shift_full_reg;
	logic                       strobe_out_reg;
	logic [PINS-1:0]            in_word_reg;
	logic                       in_valid_reg;
	logic [`CNT_WIDTH-1:0]      stamp_reg;
	logic                       event_reg;
	logic [PINS-1:0]            sample;
	logic                       cond_met;
	logic                       strobe_ok;
	logic                       do_out;
	logic                       do_in;

	// =========================================
	// input synchronisers
	// pins come from outside, two flops each
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ext_sync_reg    <= 2'h0;
			strobe_sync_reg <= 2'h0;
			pin_sync1_reg   <= '0;
			pin_sync2_reg   <= '0;
		end else begin
			ext_sync_reg    <= {ext_sync_reg[0], ext_clk_pin};
			strobe_sync_reg <= {strobe_sync_reg[0], input_ready_strobe};
			pin_sync1_reg   <= pin_in;
			pin_sync2_reg   <= pin_sync1_reg;
		end
	end

	// =========================================
	// clock blocks
	// reference enable; at 40 MHz it is every cycle, the fastest we can go
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ref_cnt_reg <= 8'h00;
		end else begin
			ref_cnt_reg <= ref_tick ? 8'h00 : ref_cnt_reg + 8'h01;
		end
	end
	assign ref_tick = (ref_cnt_reg >= 8'(`REF_DIV - 1));

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_CLKBLK; gi++) begin : g_blk
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					src_reg[gi] <= src_ref;
					div_reg[gi] <= `DIV_RESET;
				end else if (cfg_write && cfg_blk == `CLKBLK_W'(gi) && gi != 0) begin
					src_reg[gi] <= cfg_src;
					div_reg[gi] <= cfg_div;
				end
			end
			clock_block u_blk (
				.clock        (clock),
				.rst_n        (rst_n),
				.ref_tick     (ref_tick),
				.src_sel      (src_reg[gi]),
				.div_ratio    (div_reg[gi]),
				.ext_clk_sync (ext_sync_reg[1]),
				.tick         (blk_tick[gi])
			);
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sel_reg <= `CLKBLK_REF;
		end else if (clkblk_set && clkblk_sel < `CLKBLK_W'(`NUM_CLKBLK)) begin
			sel_reg <= clkblk_sel;
		end
	end
	assign tick = blk_tick[sel_reg];

	// =========================================
	// counter and timing
	// counter readable, time settable
	port_counter u_cnt (
		.clock      (clock),
		.rst_n      (rst_n),
		.tick       (tick),
		.time_armed (time_armed),
		.time_value (time_value),
		.count      (count),
		.time_hit   (time_hit)
	);

	// =========================================
	// width and pin ownership
	// mask to defined width
	always_comb begin
		unique case (width_sel)
			w1:  width_mask = PINS'(32'h0000_0001);
			w4:  width_mask = PINS'(32'h0000_000F);
			w8:  width_mask = PINS'(32'h0000_00FF);
			w16: width_mask = PINS'(32'h0000_FFFF);
			w32: width_mask = PINS'(32'hFFFF_FFFF);
			default: width_mask = '0;
		endcase
	end
	assign own_mask = (port_enable && !link_enable) ? (width_mask & ~narrow_claim) : '0;

	// =========================================
	// output path
	// transfer register feeds shift_reg, put on the pins whole
	assign out_ready = !xfer_full_reg;
	assign do_out = dir_out && shift_full_reg && tick && time_hit;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			xfer_reg      <= '0;
			xfer_full_reg <= 1'b0;
		end else if (out_req && !xfer_full_reg && dir_out) begin
			xfer_reg      <= out_word & width_mask;
			xfer_full_reg <= 1'b1;
		end else if (xfer_full_reg && (!shift_full_reg || do_out)) begin
			xfer_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			shift_reg      <= '0;
			shift_full_reg <= 1'b0;
		end else if (xfer_full_reg && (!shift_full_reg || do_out)) begin
			shift_reg      <= xfer_reg;
			shift_full_reg <= 1'b1;
		end else if (do_out) begin
			shift_full_reg <= 1'b0;
		end
	end

	// pin value holds the last word after it is sent
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_out        <= '0;
			strobe_out_reg <= 1'b0;
		end else begin
			strobe_out_reg <= do_out;
			if (do_out) begin
				pin_out <= shift_reg;
			end
		end
	end
	assign output_qualify_strobe = strobe_out_reg;

	// drive or float per bit
	// pin_oe_n low means driving
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_pin
			assign pin_oe_n[gi] = !(own_mask[gi] && dir_out &&
				!(open_drain && pin_out[gi]));
		end
	endgenerate

	// =========================================
	// input path
	// unowned pins read as zero, word full width
	assign sample = pin_sync2_reg & own_mask;
	always_comb begin
		unique case (cond_mode)
			cond_equal:  cond_met = (sample == (cond_value & width_mask));
			cond_differ: cond_met = (sample != (cond_value & width_mask));
			default:     cond_met = 1'b1;
		endcase
	end
	assign strobe_ok = !strobe_in_enable || strobe_sync_reg[1];
	assign do_in = !dir_out && in_req && tick && time_hit && cond_met && strobe_ok;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			in_word_reg  <= '0;
			in_valid_reg <= 1'b0;
		end else begin
			in_valid_reg <= do_in;
			if (do_in) begin
				in_word_reg <= sample;
			end
		end
	end
	assign in_word  = in_word_reg;
	assign in_valid = in_valid_reg;

	// =========================================
	// timestamp and event
	// counter captured on transfer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stamp_reg <= `CNT_RESET;
		end else if (do_in || do_out) begin
			stamp_reg <= count;
		end
	end
	assign timestamp = stamp_reg;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			event_reg <= 1'b0;
		end else begin
			event_reg <= do_in || do_out;
		end
	end
	assign port_event = event_reg;
endmodule

// *** testbench/timed_io_port_checker.sv ***
// concurrent checks on the timed port pins and handshakes
`timescale 1ns/100ps
`include "timed_port_regs.svh"
module timed_io_port_checker #(
	parameter int PINS = 32
)(
	input wire logic                  clock,
	input wire logic                  rst_n,
	input wire logic                  dir_out,
	input wire logic                  open_drain,
	input wire logic                  link_enable,
	input wire logic [PINS-1:0]       narrow_claim,
	input wire logic                  time_armed,
	input wire logic [`CNT_WIDTH-1:0] time_value,
	input wire logic                  out_req,
	input wire logic                  out_ready,
	input wire logic [PINS-1:0]       pin_out,
	input wire logic [PINS-1:0]       pin_oe_n,
	input wire logic                  output_qualify_strobe,
	input wire logic                  port_event,
	input wire logic [`CNT_WIDTH-1:0] count,
	input wire logic [`CNT_WIDTH-1:0] timestamp
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// pin ownership
	no_drive_in_a: assert property (!dir_out |-> &pin_oe_n)
		else $error("input port drives pins");
	link_release_a: assert property (link_enable |-> &pin_oe_n)
		else $error("pins driven under link");
	claim_yield_a: assert property (!(|(narrow_claim & ~pin_oe_n)))
		else $error("claimed pin driven");
	open_drain_a: assert property (open_drain |-> !(|(pin_out & ~pin_oe_n)))
		else $error("open drain drives high");
	// ==========================================
	// transfers and timing
	pin_hold_a: assert property ($changed(pin_out) |-> output_qualify_strobe)
		else $error("pins changed without strobe");
	event_pair_a: assert property (output_qualify_strobe |-> port_event)
		else $error("transfer without event");
	stamp_match_a: assert property (output_qualify_strobe |-> timestamp == $past(count))
		else $error("timestamp not counter");
	timed_start_a: assert property (output_qualify_strobe && $past(time_armed)
		|-> $past(count) == $past(time_value))
		else $error("timed transfer off time");
	take_fill_a: assert property (out_req && out_ready && dir_out |=> !out_ready)
		else $error("taken word not held");
	count_step_a: assert property (count == $past(count)
		|| count == $past(count) + `CNT_STEP)
		else $error("counter jumped");
endmodule

bind timed_io_port timed_io_port_checker #(.PINS(PINS)) chk (.clock(clock), .rst_n(rst_n),
	.dir_out(dir_out), .open_drain(open_drain), .link_enable(link_enable),
	.narrow_claim(narrow_claim), .time_armed(time_armed), .time_value(time_value),
	.out_req(out_req), .out_ready(out_ready), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
	.output_qualify_strobe(output_qualify_strobe), .port_event(port_event),
	.count(count), .timestamp(timestamp));

// *** testbench/pin_partner.sv ***
// external pins: pull-downs, driven input data, strobe capture, app clock
`timescale 1ns/100ps
module pin_partner (
	input  wire logic        clock,
	input  wire logic [31:0] pin_out,
	input  wire logic [31:0] pin_oe_n,
	input  wire logic        output_qualify_strobe,
	input  wire logic [31:0] drive_val,
	input  wire logic        drive_en,
	output logic [31:0]      pin_in,
	output logic [31:0]      seen_word,
	output logic             ext_clk
);
	logic [31:0] wire_lvl;
	// undriven pins fall to the pull-down level
	assign wire_lvl = pin_out & ~pin_oe_n;
	assign pin_in = drive_en ? drive_val : wire_lvl;
	always @(posedge clock) begin
		if (output_qualify_strobe === 1'b1) begin
			seen_word <= wire_lvl;
		end
	end
	// free app clock, 200 ns, phase off the system clock
	// seen_word has one driver only: it is unknown until the first strobe
	initial begin
		ext_clk = 1'b0;
		#7;
		forever #100 ext_clk = ~ext_clk;
	end
endmodule

// *** testbench/timed_io_port_test.sv ***
// self-checking bench for the timed port
`timescale 1ns/100ps
`include "timed_port_regs.svh"
module timed_io_port_test;
	import timed_port_pkg::*;
	logic clock = 1'b0, rst_n = 1'b0, port_enable, dir_out, open_drain, link_enable;
	logic clkblk_set, cfg_write, time_armed, out_req, in_req, strobe_in_enable;
	logic input_ready_strobe, drive_en, ext_clk_pin, output_qualify_strobe;
	logic out_ready, in_valid, port_event;
	port_width_e width_sel;
	cond_mode_e cond_mode;
	clk_src_e cfg_src;
	logic [2:0] clkblk_sel, cfg_blk;
	logic [7:0] cfg_div;
	logic [15:0] time_value, count, timestamp, c0;
	logic [31:0] narrow_claim, cond_value, out_word, drive_val, pin_in, pin_out, pin_oe_n;
	logic [31:0] in_word, seen;
	int fail_count = 0, total_checks = 0, cycles = 0, vcount = 0, i;

	timed_io_port #(.PINS(32)) uut (.clock(clock), .rst_n(rst_n), .port_enable(port_enable),
		.width_sel(width_sel), .dir_out(dir_out), .open_drain(open_drain),
		.link_enable(link_enable), .narrow_claim(narrow_claim), .clkblk_sel(clkblk_sel),
		.clkblk_set(clkblk_set), .cfg_blk(cfg_blk), .cfg_src(cfg_src), .cfg_div(cfg_div),
		.cfg_write(cfg_write), .ext_clk_pin(ext_clk_pin), .cond_mode(cond_mode),
		.cond_value(cond_value), .time_armed(time_armed), .time_value(time_value),
		.out_req(out_req), .out_word(out_word), .in_req(in_req),
		.strobe_in_enable(strobe_in_enable), .input_ready_strobe(input_ready_strobe),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.output_qualify_strobe(output_qualify_strobe), .out_ready(out_ready),
		.in_valid(in_valid), .in_word(in_word), .count(count), .timestamp(timestamp),
		.port_event(port_event));
	pin_partner far (.clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.output_qualify_strobe(output_qualify_strobe), .drive_val(drive_val),
		.drive_en(drive_en), .pin_in(pin_in), .seen_word(seen), .ext_clk(ext_clk_pin));

	always #12.5 clock = ~clock;
	// hang guard and input pulse counter
	always @(posedge clock) begin
		cycles++;
		if (in_valid === 1'b1) vcount++;
		// the whole sequence needs about four hundred cycles
		if (cycles == 5000) begin
			fail_count++;
			conclude();
		end
	end
	// ==========================================
	// access tasks
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	task automatic check_w(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_c(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_w(what, {16'h0000, exp}, {16'h0000, got});
	endtask
	// hold a write until an edge with out_ready high takes it
	task automatic put(input logic [31:0] w);
		int n;
		out_word = w;
		out_req = 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (out_ready !== 1'b1 && n < 50);
		// a request that was never taken counts as a mismatch
		check_w("put taken", 32'h0000_0001, {31'h0, out_ready});
		#2;
		out_req = 1'b0;
	endtask
	task automatic wait_sig(ref logic s, input int n);
		for (int k = 0; k < n && s !== 1'b1; k++) step(1);
		check_w("wait", 32'h1, {31'h0, s});
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========================================
	// main sequence
	initial begin
		{port_enable, dir_out, open_drain, link_enable, clkblk_set, cfg_write} = '0;
		{time_armed, out_req, in_req, strobe_in_enable, input_ready_strobe, drive_en} = '0;
		{clkblk_sel, cfg_blk, cfg_div, time_value} = '0;
		{narrow_claim, cond_value, out_word, drive_val} = '0;
		width_sel = w32;
		cond_mode = cond_none;
		cfg_src = src_ref;
		step(8);
		// look at the reset state before any input moves
		check_w("oe_n reset", 32'hFFFF_FFFF, pin_oe_n);
		check_w("ready reset", 32'h0000_0001, {31'h0, out_ready});
		c0 = count;
		rst_n = 1'b1;
		port_enable = 1'b1;
		dir_out = 1'b1;
		step(5);
		check_c("count rate", c0 + 16'h0005, count);
		put(32'h8421_C3E7);
		wait_sig(output_qualify_strobe, 10);
		check_c("stamp", count - 16'h0001, timestamp);
		step(1);
		check_w("out word", 32'h8421_C3E7, seen);
		width_sel = w8;
		put(32'hA5A5_1234);
		wait_sig(output_qualify_strobe, 10);
		check_w("w8 oe_n", 32'hFFFF_FF00, pin_oe_n);
		step(1);
		check_w("w8 word", 32'h0000_0034, seen);
		width_sel = w32;
		time_armed = 1'b1;
		time_value = count + 16'h0028;
		put(32'h0000_FFFF);
		wait_sig(output_qualify_strobe, 60);
		check_c("timed stamp", time_value, timestamp);
		time_armed = 1'b0;
		open_drain = 1'b1;
		step(1);
		check_w("od oe_n", 32'h0000_FFFF, pin_oe_n);
		open_drain = 1'b0;
		narrow_claim = 32'h0000_00FF;
		step(1);
		check_w("claim oe_n", 32'h0000_00FF, pin_oe_n);
		link_enable = 1'b1;
		step(1);
		check_w("link oe_n", 32'hFFFF_FFFF, pin_oe_n);
		{link_enable, narrow_claim} = '0;
		// conditional sampling, equal then differ
		{dir_out, drive_en, in_req} = 3'b011;
		width_sel = w8;
		cond_value = 32'h0000_005A;
		for (i = 0; i < 2; i++) begin
			cond_mode = i ? cond_differ : cond_equal;
			drive_val = i ? 32'hFFFF_FF5A : 32'hFFFF_FF11;
			step(4);
			c0 = vcount[15:0];
			step(8);
			check_c("held off", c0, vcount[15:0]);
			drive_val = i ? 32'hFFFF_FF33 : 32'hFFFF_FF5A;
			wait_sig(in_valid, 20);
			check_w("in word", i ? 32'h0000_0033 : 32'h0000_005A, in_word);
		end
		cond_mode = cond_none;
		strobe_in_enable = 1'b1;
		drive_val = 32'h0000_0077;
		step(4);
		c0 = vcount[15:0];
		step(8);
		check_c("no strobe", c0, vcount[15:0]);
		input_ready_strobe = 1'b1;
		step(1);
		input_ready_strobe = 1'b0;
		wait_sig(in_valid, 10);
		check_w("strobed word", 32'h0000_0077, in_word);
		{in_req, strobe_in_enable} = '0;
		// clock blocks: block 0 ignores setup, others divide or follow the pin
		for (i = 0; i < 4; i++) begin
			cfg_blk = i == 0 ? 3'h0 : 3'(i + 1);
			cfg_src = i < 2 ? src_divided_ref : src_pin;
			cfg_div = i == 3 ? 8'h01 : (i < 2 ? 8'h03 : 8'h00);
			cfg_write = 1'b1;
			step(1);
			{cfg_write, clkblk_set, clkblk_sel} = {2'b01, cfg_blk};
			step(1);
			clkblk_set = 1'b0;
			step(4);
			c0 = count;
			for (int k = 0; k < 40 && count === c0; k++) step(1);
			c0 = count;
			step(i < 2 ? 40 : 80);
			check_c("ticks", i == 0 ? 16'h0028 : (i == 3 ? 16'h0005 : 16'h000A), count - c0);
		end
		conclude();
	end
endmodule
